// file: common/supply_seq_pkg.sv
// Function
// [R1] controller owns all supply and enable ordering
// [R2] offset, bias, reset wait for settled logic
// [R3] bias and reset after offset plus 2ms
// [R4] enable released 20us after bias settled
// [R5] core supply held 50us after shutdown
// [R6] logic supplies held until mirrors discharged
// [R7] bias and reset order between them free
// [R8] logic inputs low until logic supplies settle
// [R9] software issues global bias after power-up
// [R10] park completes before hardware power-down
// [R11] power loss: emergency park, enable low
// [R12] counter-timed delays; reset holds everything off
// [R13] ordered visible states, each waits settle/timer
package supply_seq_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ               = 10000000;
    localparam int OFFSET_TO_BIAS_US    = 2000;  // nominal 2 ms, min 1 ms
    localparam int BIAS_TO_ENABLE_US    = 20;
    localparam int LOGIC_HOLD_US        = 50;
    localparam int OFFSET_TO_BIAS_CYC   =
        (OFFSET_TO_BIAS_US * (CLK_HZ / 1000000));
    localparam int BIAS_TO_ENABLE_CYC   =
        (BIAS_TO_ENABLE_US * (CLK_HZ / 1000000));
    localparam int LOGIC_HOLD_CYC       =
        (LOGIC_HOLD_US * (CLK_HZ / 1000000));
    localparam int TIMER_W              = 16;

    // ------------------------------------------------------------------
    // sequencer states, gray along power-up then power-down
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_OFF       = 4'h0,
        ST_LOGIC_ON  = 4'h1,
        ST_OFFSET_ON = 4'h3,
        ST_OFS_WAIT  = 4'h2,
        ST_BIAS_ON   = 4'h6,
        ST_EN_WAIT   = 4'h7,
        ST_RUN       = 4'h5,
        ST_PARK      = 4'h4,
        ST_DISCHARGE = 4'hc,
        ST_HOLD      = 4'hd,
        ST_DONE      = 4'hf
    } seq_state_t;

endpackage

// file: rtl/supply_sequencer.sv
`timescale 1ns/100ps
module supply_sequencer (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           power_up_req,
    input  wire logic                           power_down_req,
    input  wire logic                           park_done,
    input  wire logic                           power_loss,
    input  wire logic                           logic_pgood,
    input  wire logic                           offset_pgood,
    input  wire logic                           bias_pgood,
    input  wire logic                           reset_pgood,
    input  wire logic                           mirrors_discharged,
    output logic                                core_logic_en,
    output logic                                array_logic_en,
    output logic                                mirror_offset_en,
    output logic                                mirror_bias_en,
    output logic                                mirror_reset_en,
    output logic                                array_enable_reset_n,
    output logic                                logic_inputs_en,
    output logic                                global_bias_req,
    output logic                                park_req,
    output logic                                emergency_park,
    output logic                                seq_ready,
    output logic [3:0]                          seq_state
);
    import supply_seq_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers: three flops, change taken when 2nd and 3rd agree
    // ------------------------------------------------------------------
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    assign raw_in = {power_loss, park_done, logic_pgood, offset_pgood,
                     bias_pgood, reset_pgood, mirrors_discharged};

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_filt
            always_ff @(posedge clk) begin
                if (rst)
                    filt_reg[gi] <= 1'b0;
                else if (s2_reg[gi] == s3_reg[gi])
                    filt_reg[gi] <= s3_reg[gi];
            end
        end
    endgenerate

    logic loss_s, park_s, logic_s, ofs_s, bias_s, rstv_s, dis_s;
    assign {loss_s, park_s, logic_s, ofs_s, bias_s, rstv_s, dis_s} = filt_reg;

    // ------------------------------------------------------------------
    // state machine and delay timer
    // ------------------------------------------------------------------
    seq_state_t state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg;
    logic               timer_load;
    logic [TIMER_W-1:0] timer_load_val;
    logic               timer_done;
    assign timer_done = (timer_reg == '0);

    // power loss forces the park path from any powered state
    always_comb begin
        state_next     = state_reg;
        timer_load     = 1'b0;
        timer_load_val = '0;
        case (state_reg)
            ST_OFF: begin
                if (power_up_req && !loss_s)
                    state_next = ST_LOGIC_ON;
            end
            ST_LOGIC_ON: begin
                if (logic_s)                             // [R2] [R13]
                    state_next = ST_OFFSET_ON;
            end
            ST_OFFSET_ON: begin
                if (ofs_s) begin
                    state_next     = ST_OFS_WAIT;
                    timer_load     = 1'b1;
                    timer_load_val = TIMER_W'(OFFSET_TO_BIAS_CYC - 1);
                end
            end
            ST_OFS_WAIT: begin
                if (timer_done)                          // [R3]
                    state_next = ST_BIAS_ON;
            end
            ST_BIAS_ON: begin
                if (bias_s && rstv_s) begin              // [R7]
                    state_next     = ST_EN_WAIT;
                    timer_load     = 1'b1;
                    timer_load_val = TIMER_W'(BIAS_TO_ENABLE_CYC - 1);
                end
            end
            ST_EN_WAIT: begin
                if (timer_done)                          // [R4]
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                if (power_down_req)                      // [R10]
                    state_next = ST_PARK;
            end
            ST_PARK: begin
                if (park_s)                              // [R10]
                    state_next = ST_DISCHARGE;
            end
            ST_DISCHARGE: begin
                if (dis_s) begin                         // [R6]
                    state_next     = ST_HOLD;
                    timer_load     = 1'b1;
                    timer_load_val = TIMER_W'(LOGIC_HOLD_CYC - 1);
                end
            end
            ST_HOLD: begin
                if (timer_done)                          // [R5]
                    state_next = ST_DONE;
            end
            ST_DONE: begin
                if (!power_up_req)
                    state_next = ST_OFF;
            end
            default: state_next = ST_OFF;
        endcase
        // [R11] loss skips software park wait; hardware parks at once
        if (loss_s && state_reg != ST_OFF && state_reg != ST_DISCHARGE &&
            state_reg != ST_HOLD && state_reg != ST_DONE) begin
            state_next = ST_DISCHARGE;
            timer_load = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            state_reg <= ST_OFF;                         // [R12]
        else
            state_reg <= state_next;
    end

    // counter of known clock measures each minimum delay
    always_ff @(posedge clk) begin
        if (rst)
            timer_reg <= '0;
        else if (timer_load)
            timer_reg <= timer_load_val;                 // [R12]
        else if (!timer_done)
            timer_reg <= timer_reg - TIMER_W'(1);
    end

    // ------------------------------------------------------------------
    // registered outputs, decoded from the next state; emergency_park from the current state, global_bias_req from both
    // ------------------------------------------------------------------
    function automatic logic in_set(seq_state_t s, seq_state_t a,
                                    seq_state_t b, seq_state_t c,
                                    seq_state_t d);
        in_set = (s == a) || (s == b) || (s == c) || (s == d);
    endfunction

    logic logic_on_next, offset_on_next, bias_on_next;
    assign logic_on_next  = (state_next != ST_OFF) && (state_next != ST_DONE);
    assign offset_on_next = in_set(state_next, ST_OFFSET_ON, ST_OFS_WAIT,
                                   ST_BIAS_ON, ST_EN_WAIT) ||
                            in_set(state_next, ST_RUN, ST_PARK, ST_PARK,
                                   ST_PARK);
    assign bias_on_next   = in_set(state_next, ST_BIAS_ON, ST_EN_WAIT,
                                   ST_RUN, ST_PARK);

    // supply enables; bias and reset switch together, order is free
    always_ff @(posedge clk) begin
        if (rst) begin
            core_logic_en    <= 1'b0;
            array_logic_en   <= 1'b0;
            mirror_offset_en <= 1'b0;
            mirror_bias_en   <= 1'b0;
            mirror_reset_en  <= 1'b0;
        end else begin
            core_logic_en    <= logic_on_next;           // [R1] [R5] [R6]
            array_logic_en   <= logic_on_next;           // [R6]
            mirror_offset_en <= offset_on_next;          // [R2]
            mirror_bias_en   <= bias_on_next;            // [R3] [R7]
            mirror_reset_en  <= bias_on_next;            // [R7]
        end
    end

    // enable line asserted only in run and park; low otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            array_enable_reset_n <= 1'b0;                // [R12]
            logic_inputs_en      <= 1'b0;
        end else begin
            array_enable_reset_n <= (state_next == ST_RUN) ||
                                    (state_next == ST_PARK);  // [R4] [R11]
            logic_inputs_en      <= logic_on_next && logic_s &&
                                    (state_next != ST_LOGIC_ON);  // [R8]
        end
    end

    // handshakes to controller software and status
    always_ff @(posedge clk) begin
        if (rst) begin
            global_bias_req <= 1'b0;
            park_req        <= 1'b0;
            emergency_park  <= 1'b0;
            seq_ready       <= 1'b0;
            seq_state       <= ST_OFF;
        end else begin
            global_bias_req <= (state_reg == ST_EN_WAIT) &&
                               (state_next == ST_RUN);   // [R9]
            park_req        <= (state_next == ST_PARK);  // [R10]
            emergency_park  <= loss_s && (state_reg != ST_OFF) &&
                               (state_reg != ST_DONE);   // [R11]
            seq_ready       <= (state_next == ST_RUN);
            seq_state       <= state_next;               // [R13]
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    // helper ages: cycles that each condition has stood, saturating; the
    // short $past depths alone would miss a delay timer cut too early
    // bit 0 offset on, bit 1 bias and reset on, bit 2 logic on, mirrors off
    // 16 bits saturate far above the longest wait, so no wrap hides a fault
    logic [2:0]         age_run;
    logic [TIMER_W-1:0] age_reg [3];
    assign age_run = {core_logic_en && !mirror_offset_en &&
                      !mirror_bias_en && !mirror_reset_en,
                      mirror_bias_en && mirror_reset_en,
                      mirror_offset_en};

    generate
        for (gi = 0; gi < 3; gi++) begin : g_age
            always_ff @(posedge clk) begin
                if (rst || !age_run[gi])
                    age_reg[gi] <= '0;
                else if (age_reg[gi] != '1)
                    age_reg[gi] <= age_reg[gi] + TIMER_W'(1);
            end
        end
    endgenerate

    // ordering and minimum delays of the supplies
    bias_after_offset_a: assert property ( // [R3]
        @(posedge clk) disable iff (rst)
        $rose(mirror_bias_en) |-> $past(mirror_offset_en, 8) &&
        age_reg[0] >= TIMER_W'(OFFSET_TO_BIAS_CYC))
        else $error("bias enabled without offset wait");
    offset_needs_logic_a: assert property ( // [R2]
        @(posedge clk) disable iff (rst)
        mirror_offset_en |-> core_logic_en && array_logic_en)
        else $error("offset on without logic supplies");
    bias_reset_same_a: assert property ( // [R7]
        @(posedge clk) disable iff (rst)
        mirror_bias_en == mirror_reset_en)
        else $error("bias and reset enables differ");
    enable_needs_bias_a: assert property ( // [R4]
        @(posedge clk) disable iff (rst)
        $rose(array_enable_reset_n) |-> $past(mirror_bias_en, 8) &&
        age_reg[1] >= TIMER_W'(BIAS_TO_ENABLE_CYC))
        else $error("enable released too early");
    logic_held_after_a: assert property ( // [R5] [R6]
        @(posedge clk) disable iff (rst)
        $fell(mirror_offset_en) |-> core_logic_en [*8])
        else $error("logic supply dropped early");
    core_hold_time_a: assert property ( // [R5]
        @(posedge clk) disable iff (rst)
        $fell(core_logic_en) && !$past(rst) |->
        age_reg[2] >= TIMER_W'(LOGIC_HOLD_CYC))
        else $error("core supply not held long enough");

    // enable line, handshakes and reset state
    inputs_low_a: assert property ( // [R8]
        @(posedge clk) disable iff (rst)
        logic_inputs_en |-> core_logic_en)
        else $error("logic inputs driven without supply");
    bias_cmd_pulse_a: assert property ( // [R9]
        @(posedge clk) disable iff (rst)
        global_bias_req |-> array_enable_reset_n ##1 !global_bias_req)
        else $error("bias command not one pulse in run");
    park_before_off_a: assert property ( // [R10]
        @(posedge clk) disable iff (rst)
        $fell(mirror_offset_en) && !$past(rst) |->
        $past(park_s) || $past(loss_s))
        else $error("mirror supplies off before park done");
    loss_enable_low_a: assert property ( // [R11]
        @(posedge clk) disable iff (rst)
        $rose(loss_s) && state_reg != ST_OFF |-> ##[1:3]
        !array_enable_reset_n)
        else $error("enable not low after power loss");
    reset_off_a: assert property ( // [R12]
        @(posedge clk)
        $past(rst) |-> !array_enable_reset_n && !mirror_bias_en)
        else $error("outputs active after reset");

endmodule

// file: verification/supply_model.sv
`timescale 1ns/100ps
// regulators and mirror array pins: ramps each supply after its enable
module supply_model #(
    parameter int RISE = 8
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic core_logic_en,
    input  wire logic array_logic_en,
    input  wire logic mirror_offset_en,
    input  wire logic mirror_bias_en,
    input  wire logic mirror_reset_en,
    input  wire logic array_enable_reset_n,
    input  wire logic logic_inputs_en,
    output logic      logic_pgood,
    output logic      offset_pgood,
    output logic      bias_pgood,
    output logic      reset_pgood,
    output logic      mirrors_discharged,
    output int        viol
);
    logic [3:0] en;
    int         up [4];
    int         dn;
    logic       core_prev;

    // ------------------------------------------------------------------
    // supply ramps
    // ------------------------------------------------------------------
    // bias and reset settle at different times, bias always three cycles before reset
    assign en = {mirror_reset_en, mirror_bias_en, mirror_offset_en,
                 core_logic_en & array_logic_en};
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (rst || !en[i]) up[i] <= 0;
            else if (up[i] < RISE + 3 * i) up[i] <= up[i] + 1;
        end
        if (rst || en[3:1] != 3'h0) dn <= 0;
        else if (dn < RISE) dn <= dn + 1;
    end
    assign logic_pgood        = (up[0] == RISE);
    assign offset_pgood       = (up[1] == RISE + 3);
    assign bias_pgood         = (up[2] == RISE + 6);
    assign reset_pgood        = (up[3] == RISE + 9);
    assign mirrors_discharged = (dn == RISE);

    // ------------------------------------------------------------------
    // device-side supervision of the controller's ordering
    // ------------------------------------------------------------------
    // a real array would only lose life here, so count instead of stop
    always_ff @(posedge clk) begin
        core_prev <= core_logic_en;
        if (rst) viol <= 0;
        else if ((en[3:1] != 3'h0 && !logic_pgood) ||
                 (logic_inputs_en && !logic_pgood) ||
                 (array_enable_reset_n && !(bias_pgood && reset_pgood)) ||
                 (core_prev && !core_logic_en && !mirrors_discharged))
            viol <= viol + 1;
    end
endmodule

// file: verification/test_supply_sequencer.sv
`timescale 1ns/100ps
module test_supply_sequencer;
    import supply_seq_pkg::*;
    logic clk = 1'b0, rst = 1'b1, up_req = 1'b0, down_req = 1'b0;
    logic park_done = 1'b0, loss = 1'b0;
    logic lpg, opg, bpg, rpg, dis, core_en, arr_en, ofs_en, bias_en, rst_en;
    logic en_n, in_en, gbias, park, epark, ready;
    logic [3:0] state;
    int viol, fail_count = 0, checks = 0, cyc = 0, t0;

    supply_sequencer i_dut (.clk(clk), .rst(rst), .power_up_req(up_req),
        .power_down_req(down_req), .park_done(park_done),
        .power_loss(loss), .logic_pgood(lpg), .offset_pgood(opg),
        .bias_pgood(bpg), .reset_pgood(rpg), .mirrors_discharged(dis),
        .core_logic_en(core_en), .array_logic_en(arr_en),
        .mirror_offset_en(ofs_en), .mirror_bias_en(bias_en),
        .mirror_reset_en(rst_en), .array_enable_reset_n(en_n),
        .logic_inputs_en(in_en), .global_bias_req(gbias),
        .park_req(park), .emergency_park(epark), .seq_ready(ready),
        .seq_state(state));
    supply_model i_model (.clk(clk), .rst(rst), .core_logic_en(core_en),
        .array_logic_en(arr_en), .mirror_offset_en(ofs_en),
        .mirror_bias_en(bias_en), .mirror_reset_en(rst_en),
        .array_enable_reset_n(en_n), .logic_inputs_en(in_en),
        .logic_pgood(lpg), .offset_pgood(opg), .bias_pgood(bpg),
        .reset_pgood(rpg), .mirrors_discharged(dis), .viol(viol));

    // ------------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ------------------------------------------------------------------
    always #50 clk = ~clk;
    // two power-ups of about 20000 cycles each plus margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            results();
        end
    end
    task automatic check(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (fail_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_power_up();
        up_req <= 1'b1;
        @(posedge clk iff core_en);
        check(ofs_en | in_en, 1'b0);
        @(posedge clk iff opg);
        t0 = cyc;
        @(posedge clk iff bias_en & rst_en);
        check(cyc - t0 >= 10000, 1'b1);
        @(posedge clk iff bpg & rpg);
        t0 = cyc;
        @(posedge clk iff en_n);
        check(cyc - t0 >= 200, 1'b1);
        check(gbias & ready & in_en, 1'b1);
        check(state === ST_RUN, 1'b1);
        @(posedge clk);
        check(gbias, 1'b0);
    endtask
    task automatic t_power_down();
        down_req <= 1'b1;
        @(posedge clk iff park);
        down_req <= 1'b0;
        repeat (20) @(posedge clk);
        check(en_n & ofs_en & bias_en & rst_en, 1'b1);
        park_done <= 1'b1;
        @(posedge clk iff !en_n);
        check(ofs_en | bias_en | rst_en, 1'b0);
        check(park, 1'b0);
        @(posedge clk iff dis);
        t0 = cyc;
        check(core_en & arr_en, 1'b1);
        @(posedge clk iff !core_en);
        check(cyc - t0 >= 500, 1'b1);
        check(arr_en | in_en, 1'b0);
        repeat (2) @(posedge clk);
        check(state === ST_DONE, 1'b1);
        park_done <= 1'b0;
        up_req <= 1'b0;
        @(posedge clk iff state === ST_OFF);
    endtask
    task automatic t_power_loss();
        loss <= 1'b1;
        @(posedge clk iff !en_n);
        repeat (2) @(posedge clk);
        check(epark & !ready, 1'b1);
        check(ofs_en | bias_en | rst_en, 1'b0);
        @(posedge clk iff state === ST_DONE);
        up_req <= 1'b0;
        @(posedge clk iff state === ST_OFF);
        up_req <= 1'b1;
        repeat (50) @(posedge clk);
        check(core_en, 1'b0);
        up_req <= 1'b0;
        loss <= 1'b0;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        check(|{core_en, arr_en, ofs_en, bias_en, rst_en, en_n, in_en,
                gbias, park, epark, ready, state}, 1'b0);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_power_up();
        t_power_down();
        t_power_up();
        t_power_loss();
        check(viol == 0, 1'b1);
        results();
    end
endmodule
